/* rtl/drl_pkg.sv */
// shared constants and types of the dynamic range limiter
package drl_pkg;

    // register indices; byte address is index times four
    localparam logic [11:0] IDX_CFG    = 12'h0430;
    localparam logic [11:0] IDX_TUNE   = 12'h0434;
    localparam logic [11:0] IDX_CB_CNT = 12'h0559;
    localparam logic [11:0] IDX_CB_SEL = 12'h055A;
    localparam logic [11:0] IDX_CHSEL  = 12'h0008;
    localparam logic [11:0] IDX_STAT   = 12'h000A;

    // config register fields and register reset values
    localparam int CFG_EN    = 0;
    localparam int CFG_CPLX  = 1;
    localparam int CFG_BW43  = 2;
    localparam logic [2:0] CFG_RST    = 3'h0;
    localparam logic [3:0] TUNE_RST   = 4'h4;
    localparam logic [1:0] CB_CNT_RST = 2'h0;
    localparam logic [5:0] CB_SEL_RST = 6'h00;

    // real mode tuning limits
    localparam logic [3:0] TUNE_REAL_MIN = 4'h2;
    localparam logic [3:0] TUNE_REAL_MAX = 4'h6;

    // control bit source codes
    localparam logic [1:0] SRC_ZERO = 2'h0;
    localparam logic [1:0] SRC_PUN1 = 2'h1;
    localparam logic [1:0] SRC_PUN0 = 2'h2;
    localparam logic [1:0] SRC_FLAG = 2'h3;

    // resolutions and declared converter resolution
    localparam logic [3:0] RES_FULL   = 4'hE;
    localparam logic [4:0] N_DECL_STD = 5'h0E;
    localparam logic [4:0] N_DECL_CS3 = 5'h0D;
    localparam logic [1:0] CS_MAX     = 2'h3;

    // peak thresholds, 8192 = 0 dBFS: -30,-24,-18,-12,-6 dBFS
    localparam logic [16:0] THR_M30 = 17'h0_0103;
    localparam logic [16:0] THR_M24 = 17'h0_0205;
    localparam logic [16:0] THR_M18 = 17'h0_0407;
    localparam logic [16:0] THR_M12 = 17'h0_080A;
    localparam logic [16:0] THR_M06 = 17'h0_100A;

    // status fields
    localparam int ST_PUN  = 0;
    localparam int ST_FLAG = 2;
    localparam int ST_RES  = 4;
    localparam int ST_NDEC = 8;

    // cosine of k*2pi/16, scaled by 127
    localparam logic signed [7:0] COS_LUT [16] = '{
        8'sh7F, 8'sh75, 8'sh5A, 8'sh31, 8'sh00, -8'sh31, -8'sh5A, -8'sh75,
        -8'sh7F, -8'sh75, -8'sh5A, -8'sh31, 8'sh00, 8'sh31, 8'sh5A, 8'sh75};
    localparam logic [3:0] QUARTER = 4'h4;

    typedef struct packed {
        logic signed [13:0] a;
        logic signed [13:0] b;
    } drl_smp_t;

    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
    } drl_word_t;

endpackage

/* rtl/drl_buf2.sv */
// small valid/ready buffer in the output data path
`timescale 1ns/10ps
module drl_buf2 #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW:0]      cnt_ff;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    assign in_ready  = (cnt_ff != (PW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            if (push) wr_ptr_ff <= PW'(wr_ptr_ff + 1'b1);
            if (pop)  rd_ptr_ff <= PW'(rd_ptr_ff + 1'b1);
            cnt_ff <= (PW+1)'(cnt_ff + push - pop);
        end
    end
endmodule // drl_buf2

/* rtl/drl_top.sv */
// resolution limiter: zone peak detect, bit trimming, control bits
`timescale 1ns/10ps
module drl_top #(
    parameter int DECAY_SHIFT = 8
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // avalon-mm slave
    input  wire logic [13:0]      avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [3:0]       avs_byteenable,
    input  wire logic [31:0]      avs_writedata,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    // sample input
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire drl_pkg::drl_smp_t in_smp,
    // framed word output
    output logic                  out_valid,
    input  wire logic             out_ready,
    output drl_pkg::drl_word_t    out_word,
    // resolution state per channel
    output logic [1:0]            dr_punish_a,
    output logic [1:0]            dr_punish_b,
    output logic [1:0]            dr_reduce
);
    // shared helpers
    function automatic logic signed [15:0] mac(
        input logic signed [13:0] x0, input logic signed [7:0] k0,
        input logic signed [13:0] x1, input logic signed [7:0] k1);
        logic signed [22:0] acc;
        // widen before multiplying so the product is not cut to 14 bits
        acc = 23'(x0) * 23'(k0) + 23'(x1) * 23'(k1);
        return acc[22:7];
    endfunction

    // in-band estimate removed, leaving the zone content
    function automatic logic signed [15:0] resid(
        input logic bw43, input logic signed [15:0] y0,
        input logic signed [15:0] y1, input logic signed [15:0] y2,
        input logic signed [15:0] y3);
        logic signed [17:0] s4;
        logic signed [17:0] d2;
        s4 = 18'(y0) + 18'(y1) + 18'(y2) + 18'(y3);
        d2 = 18'(y0) - 18'(y1);
        if (bw43) return d2[16:1];
        return 16'(18'(y1) - (s4 >>> 2));
    endfunction

    function automatic logic [16:0] mag(input logic signed [15:0] re,
                                        input logic signed [15:0] im);
        logic [15:0] ar;
        logic [15:0] ai;
        ar = re[15] ? 16'(-re) : 16'(re);
        ai = im[15] ? 16'(-im) : 16'(im);
        if (ar > ai) return 17'(ar) + 17'(ai >> 1);
        return 17'(ai) + 17'(ar >> 1);
    endfunction

    function automatic logic [2:0] drop_of(input logic [16:0] pk);
        if (pk > drl_pkg::THR_M06) return 3'h5;
        if (pk > drl_pkg::THR_M12) return 3'h4;
        if (pk > drl_pkg::THR_M18) return 3'h3;
        if (pk > drl_pkg::THR_M24) return 3'h2;
        if (pk > drl_pkg::THR_M30) return 3'h1;
        return 3'h0;
    endfunction

    function automatic logic hit(input logic [13:0] adr,
                                 input logic [11:0] idx);
        return adr == {idx, 2'b00};
    endfunction

    // register bank, one set per channel
    logic [2:0]  cfg_ff    [2];
    logic [3:0]  tune_ff   [2];
    logic [1:0]  cb_cnt_ff [2];
    logic [5:0]  cb_sel_ff [2];
    logic        chsel_ff;
    logic        rd_ack_ff;
    logic [31:0] rdata_ff;

    wire wr_cfg   = hit(avs_address, drl_pkg::IDX_CFG);
    wire wr_tune  = hit(avs_address, drl_pkg::IDX_TUNE);
    wire wr_cbcnt = hit(avs_address, drl_pkg::IDX_CB_CNT);
    wire wr_cbsel = hit(avs_address, drl_pkg::IDX_CB_SEL);
    wire wr_chsel = hit(avs_address, drl_pkg::IDX_CHSEL);
    wire rd_stat  = hit(avs_address, drl_pkg::IDX_STAT);
    wire wr_go    = avs_write & avs_byteenable[0];
    wire rd_go    = avs_read & ~rd_ack_ff;

    // reads answer one cycle late, writes at once
    assign avs_waitrequest = rd_go;
    assign avs_readdata    = rdata_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 2; i++) begin
                cfg_ff[i]    <= drl_pkg::CFG_RST;
                tune_ff[i]   <= drl_pkg::TUNE_RST;
                cb_cnt_ff[i] <= drl_pkg::CB_CNT_RST;
                cb_sel_ff[i] <= drl_pkg::CB_SEL_RST;
            end
            chsel_ff <= 1'b0;
        end else if (wr_go) begin
            if (wr_cfg)   cfg_ff[chsel_ff]    <= avs_writedata[2:0];
            if (wr_tune)  tune_ff[chsel_ff]   <= avs_writedata[3:0];
            if (wr_cbcnt) cb_cnt_ff[chsel_ff] <= avs_writedata[1:0];
            if (wr_cbsel) cb_sel_ff[chsel_ff] <= avs_writedata[5:0];
            if (wr_chsel) chsel_ff            <= avs_writedata[0];
        end
    end

    // per-channel state
    logic [3:0]         ph_ff   [2];
    logic signed [15:0] yr_ff   [2][3];
    logic signed [15:0] yi_ff   [2][3];
    logic [16:0]        peak_ff [2];
    logic [2:0]         drop    [2];
    logic [1:0]         punish  [2];
    logic [15:0]        word    [2];
    logic [4:0]         n_decl  [2];

    wire push = in_valid & in_ready;

    for (genvar g = 0; g < 2; g++) begin : g_ch
        wire        en    = cfg_ff[g][drl_pkg::CFG_EN];
        wire        cplx  = cfg_ff[g][drl_pkg::CFG_CPLX];
        // real mode is limited to the narrow band
        wire        bw43  = cplx & cfg_ff[g][drl_pkg::CFG_BW43];
        wire [3:0]  tw    = tune_ff[g];
        wire        lo_tw = tw < drl_pkg::TUNE_REAL_MIN;
        wire        hi_tw = tw > drl_pkg::TUNE_REAL_MAX;
        // out-of-range real words are clamped, not rejected
        wire [3:0]  tw_r  = lo_tw ? drl_pkg::TUNE_REAL_MIN :
                            hi_tw ? drl_pkg::TUNE_REAL_MAX : tw;
        wire [3:0]  tw_e  = cplx ? tw : tw_r;
        // I on A, Q on B in complex use
        wire signed [13:0] own = (g == 0) ? in_smp.a : in_smp.b;
        wire signed [13:0] xi  = cplx ? in_smp.a : own;
        wire signed [13:0] xq  = cplx ? in_smp.b : 14'sh0000;
        wire signed [7:0]  c   = drl_pkg::COS_LUT[ph_ff[g]];
        wire signed [7:0]  s   =
            drl_pkg::COS_LUT[4'(ph_ff[g] - drl_pkg::QUARTER)];
        // shift the protected centre to zero
        wire signed [15:0] y0r = mac(xi, c, xq, s);
        wire signed [15:0] y0i = mac(xq, c, xi, -s);
        // the wider band keeps a shorter averager
        wire signed [15:0] rr  = resid(bw43, y0r, yr_ff[g][0],
                                       yr_ff[g][1], yr_ff[g][2]);
        wire signed [15:0] ri  = resid(bw43, y0i, yi_ff[g][0],
                                       yi_ff[g][1], yi_ff[g][2]);
        wire [16:0] m   = mag(rr, ri);
        wire [16:0] dec = peak_ff[g] - (peak_ff[g] >> DECAY_SHIFT);

        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                ph_ff[g]   <= '0;
                peak_ff[g] <= '0;
                for (int k = 0; k < 3; k++) begin
                    yr_ff[g][k] <= '0;
                    yi_ff[g][k] <= '0;
                end
            end else if (push) begin
                ph_ff[g]    <= 4'(ph_ff[g] + tw_e);
                yr_ff[g][0] <= y0r;
                yi_ff[g][0] <= y0i;
                for (int k = 1; k < 3; k++) begin
                    yr_ff[g][k] <= yr_ff[g][k-1];
                    yi_ff[g][k] <= yi_ff[g][k-1];
                end
                // fast attack, slow release
                if (!en)           peak_ff[g] <= '0;
                else if (m > dec)  peak_ff[g] <= m;
                else               peak_ff[g] <= dec;
            end
        end

        // at most five bits are dropped, so 9 always survive
        assign drop[g] = en ? drop_of(peak_ff[g]) : 3'h0;
        assign punish[g] = (drop[g] == 3'h0) ? 2'b00 :
                           (drop[g] == 3'h1) ? 2'b01 :
                           (drop[g] <= 3'h3) ? 2'b10 : 2'b11;
        wire flag = (drop[g] != 3'h0);

        // no scaling, only masking of the low bits
        wire [13:0] msk  = 14'h3FFF << drop[g];
        wire [13:0] trim = own & msk;

        function automatic logic pick(input logic [1:0] sel,
                                      input logic [1:0] pn,
                                      input logic fl);
            case (sel)
                drl_pkg::SRC_PUN1: return pn[1];
                drl_pkg::SRC_PUN0: return pn[0];
                drl_pkg::SRC_FLAG: return fl;
                default:           return 1'b0;
            endcase
        endfunction

        wire [1:0] cs  = cb_cnt_ff[g];
        wire       cb2 = (cs != 2'h0) &
                         pick(cb_sel_ff[g][5:4], punish[g], flag);
        wire       cb1 = (cs >= 2'h2) &
                         pick(cb_sel_ff[g][3:2], punish[g], flag);
        wire       cb0 = pick(cb_sel_ff[g][1:0], punish[g], flag);
        wire       cs3 = (cs == drl_pkg::CS_MAX);
        // third control bit takes the sample lsb, so N drops to 13
        assign word[g] = {trim[13:1], cs3 ? cb0 : trim[0], cb2, cb1};
        assign n_decl[g] = cs3 ? drl_pkg::N_DECL_CS3 :
                                 drl_pkg::N_DECL_STD;
    end

    // status of the selected channel
    wire [3:0]  res_sel  = 4'(drl_pkg::RES_FULL - drop[chsel_ff]);
    wire [31:0] stat_val =
        (32'(punish[chsel_ff]) << drl_pkg::ST_PUN) |
        (32'(drop[chsel_ff] != 3'h0) << drl_pkg::ST_FLAG) |
        (32'(res_sel) << drl_pkg::ST_RES) |
        (32'(n_decl[chsel_ff]) << drl_pkg::ST_NDEC);
    wire [31:0] rd_mux =
        hit(avs_address, drl_pkg::IDX_CFG)    ? 32'(cfg_ff[chsel_ff]) :
        hit(avs_address, drl_pkg::IDX_TUNE)   ? 32'(tune_ff[chsel_ff]) :
        hit(avs_address, drl_pkg::IDX_CB_CNT) ? 32'(cb_cnt_ff[chsel_ff]) :
        hit(avs_address, drl_pkg::IDX_CB_SEL) ? 32'(cb_sel_ff[chsel_ff]) :
        hit(avs_address, drl_pkg::IDX_CHSEL)  ? 32'(chsel_ff) :
        rd_stat                               ? stat_val : 32'h0000_0000;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ack_ff <= 1'b0;
            rdata_ff  <= '0;
        end else begin
            rd_ack_ff <= rd_go;
            if (rd_go) rdata_ff <= rd_mux;
        end
    end

    // state outputs straight from the peak registers
    assign dr_punish_a = punish[0];
    assign dr_punish_b = punish[1];
    assign dr_reduce   = {drop[1] != 3'h0, drop[0] != 3'h0};

    // stall at the output reaches the sample source
    drl_buf2 #(
        .WIDTH ($bits(drl_pkg::drl_word_t)),
        .DEPTH (2)
    ) u_buf (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   ({word[0], word[1]}),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_word)
    );
endmodule // drl_top

/* testbench/drl_top_asserts.sv */
// concurrent checks on the limiter top ports
`timescale 1ns/10ps
module drl_top_asserts (
    // clock and reset
    input wire logic               sys_clk,
    input wire logic               reset_n,
    // register bus
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest,
    // stream
    input wire logic               in_valid,
    input wire logic               in_ready,
    input wire logic               out_valid,
    input wire logic               out_ready,
    input wire drl_pkg::drl_word_t out_word,
    // resolution state
    input wire logic [1:0]         dr_punish_a,
    input wire logic [1:0]         dr_punish_b,
    input wire logic [1:0]         dr_reduce
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_wr_nowait;
        avs_write |-> !avs_waitrequest;
    endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_rd_wait;
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read not one wait");
    property p_rd_upper;
        avs_read && !avs_waitrequest |-> avs_readdata[31:13] == 19'h0_0000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
    property p_out_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_word);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("word lost");
    property p_full;
        !in_ready |-> out_valid;
    endproperty
    a_full: assert property (p_full) else $error("refused while empty");
    property p_lat;
        in_valid && in_ready && !out_valid |=> out_valid;
    endproperty
    a_lat: assert property (p_lat) else $error("word late");
    property p_flag_a;
        dr_reduce[0] == (dr_punish_a != 2'h0);
    endproperty
    a_flag_a: assert property (p_flag_a) else $error("flag a wrong");
    property p_flag_b;
        dr_reduce[1] == (dr_punish_b != 2'h0);
    endproperty
    a_flag_b: assert property (p_flag_b) else $error("flag b wrong");
    c_read: cover property (avs_read && !avs_waitrequest);
    c_stall: cover property (out_valid && !out_ready ##1 out_valid);
    c_reduce: cover property (dr_reduce[0]);
endmodule // drl_top_asserts

bind drl_top drl_top_asserts chk_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
    .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
    .out_word(out_word), .dr_punish_a(dr_punish_a),
    .dr_punish_b(dr_punish_b), .dr_reduce(dr_reduce)
);

/* testbench/drl_sink.sv */
// downstream word sink with stall control
`timescale 1ns/10ps
module drl_sink (
    // clock and reset
    input wire logic               sys_clk,
    input wire logic               reset_n,
    // stall request
    input wire logic               stall,
    // stream from the limiter
    input wire logic               out_valid,
    output logic                   out_ready,
    input wire drl_pkg::drl_word_t out_word,
    // what was taken
    output drl_pkg::drl_word_t     last_ff,
    output logic [15:0]            count_ff
);
    // ready follows stall only, so a held word must wait
    assign out_ready = !stall;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            last_ff  <= '0;
            count_ff <= '0;
        end else if (out_valid && out_ready) begin
            last_ff  <= out_word;
            count_ff <= count_ff + 16'h0001;
        end
    end
endmodule // drl_sink

/* testbench/tb_top.sv */
// self-checking bench of the resolution limiter
`timescale 1ns/10ps
module tb_top;
    logic               sys_clk = 1'b0;
    logic               reset_n = 1'b0;
    logic [13:0]        avs_address = '0;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic [3:0]         avs_byteenable = 4'h0;
    logic [31:0]        avs_writedata = '0;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic               in_valid = 1'b0;
    logic               in_ready;
    drl_pkg::drl_smp_t  in_smp = '0;
    logic               out_valid;
    logic               out_ready;
    drl_pkg::drl_word_t out_word;
    drl_pkg::drl_word_t last_w;
    logic [15:0]        cnt;
    logic [15:0]        c0;
    logic [1:0]         dr_punish_a;
    logic [1:0]         dr_punish_b;
    logic [1:0]         dr_reduce;
    logic               stall = 1'b0;
    logic [31:0]        rd;
    int                 failures = 0;
    int                 checks = 0;
    localparam logic [13:0] A_CFG = {drl_pkg::IDX_CFG, 2'b00};
    localparam logic [13:0] A_TUN = {drl_pkg::IDX_TUNE, 2'b00};
    localparam logic [13:0] A_CNT = {drl_pkg::IDX_CB_CNT, 2'b00};
    localparam logic [13:0] A_SEL = {drl_pkg::IDX_CB_SEL, 2'b00};
    localparam logic [13:0] A_CHS = {drl_pkg::IDX_CHSEL, 2'b00};
    localparam logic [13:0] A_STA = {drl_pkg::IDX_STAT, 2'b00};
    localparam logic [31:0] ONES = 32'hFFFF_FFFF;
    // rows: address, written value, value read back
    localparam logic [13:0] R_A [13] = '{A_CFG, A_TUN, A_CNT, A_SEL,
        14'h0004, A_CHS, A_STA, A_CFG, A_CHS, A_STA, A_CFG, A_TUN, A_CNT};
    localparam logic [31:0] R_W [13] = '{ONES, ONES, ONES, ONES, ONES,
        ONES, ONES, 32'h0000_0000, 32'h0000_0000, ONES, 32'h0000_0001,
        32'h0000_0004, 32'h0000_0000};
    localparam logic [31:0] R_E [13] = '{32'h0000_0007, 32'h0000_000F,
        32'h0000_0003, 32'h0000_003F, 32'h0000_0000, 32'h0000_0001,
        32'h0000_0EE0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0DE0,
        32'h0000_0001, 32'h0000_0004, 32'h0000_0000};
    // stream rows: level, expected indicator, expected word of a
    localparam logic [13:0] S_L [4] = '{14'h0000, 14'h0065, 14'h1FFF,
        14'h0065};
    localparam logic [1:0] S_P [4] = '{2'h0, 2'h0, 2'h3, 2'h0};
    localparam logic [15:0] S_W [4] = '{16'h0000, 16'h0194, 16'h7F80,
        16'h0194};

    always #12.5 sys_clk = ~sys_clk;

    drl_top #(.DECAY_SHIFT(2)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .in_valid(in_valid), .in_ready(in_ready), .in_smp(in_smp),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
        .dr_punish_a(dr_punish_a), .dr_punish_b(dr_punish_b),
        .dr_reduce(dr_reduce)
    );
    drl_sink snk_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .stall(stall),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
        .last_ff(last_w), .count_ff(cnt)
    );

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [13:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        if (n == 50) failures++;
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask
    // a carries in-phase, b quadrature when complex
    task automatic push(input logic [13:0] v, input int k);
        int n;
        n = 0;
        in_smp <= {v, v};
        in_valid <= 1'b1;
        repeat (k) begin
            @(posedge sys_clk);
            while (in_ready !== 1'b1 && n < 50) begin
                n++;
                @(posedge sys_clk);
            end
        end
        if (n == 50) failures++;
        in_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, A_TUN, '0, 4'h1);
        check("tune reset", rd, 32'h0000_0004);
        for (int i = 0; i < 13; i++) begin
            bus(1'b1, R_A[i], R_W[i], 4'h1);
            bus(1'b0, R_A[i], '0, 4'h1);
            check("register", rd, R_E[i]);
        end
        bus(1'b1, A_TUN, 32'h0000_0009, 4'h0);
        bus(1'b0, A_TUN, '0, 4'h1);
        check("lane off write", rd, 32'h0000_0004);
        for (int i = 0; i < 4; i++) begin
            push(S_L[i], 40);
            check("word a", last_w.a, S_W[i]);
            check("word b", last_w.b, {S_L[i], 2'b00});
            check("indicator a", dr_punish_a, S_P[i]);
            check("indicator b", dr_punish_b, 2'h0);
        end
        // three control bits: flag, indicator high, indicator low
        bus(1'b1, A_CNT, 32'h0000_0003, 4'h1);
        bus(1'b1, A_SEL, 32'h0000_0036, 4'h1);
        push(14'h1FFF, 10);
        check("cs3 word", last_w.a, 16'h7F87);
        bus(1'b0, A_STA, '0, 4'h1);
        check("status", rd, 32'h0000_0D97);
        bus(1'b1, A_CNT, 32'h0000_0001, 4'h1);
        bus(1'b1, A_SEL, 32'h0000_003F, 4'h1);
        push(14'h1FFF, 10);
        check("cs1 word", last_w.a, 16'h7F82);
        bus(1'b0, A_STA, '0, 4'h1);
        check("status n", rd[12:8], 32'h0000_000E);
        // complex 43%, centre 0: full-scale dc is in band, no reduction
        bus(1'b1, A_CFG, 32'h0000_0007, 4'h1);
        bus(1'b1, A_TUN, 32'h0000_0000, 4'h1);
        push(14'h1FFF, 40);
        check("in band a", dr_punish_a, 2'h0);
        check("in band word", last_w.a, 16'h7FFC);
        c0 = cnt;
        stall <= 1'b1;
        push(14'h0005, 2);
        check("full", in_ready, 1'b0);
        stall <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check("drained", cnt - c0, 32'h0000_0002);
        check("empty", out_valid, 1'b0);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        stop_test();
    end
endmodule // tb_top
